// ==== low_leakage_wakeup_unit_defines.svh ====
// constants and rule summary for the low-leakage wakeup unit
// Operation
// - sixteen external pins and eight internal modules, each individually selectable; here only pins 0..7 have edge selects
// - any wakeup event in low_leak_stop exits through an interrupt flow
// - any wakeup event in very_low_leak_stop exits through a reset flow
// - outside low-leakage modes detection logic is inactive and static; here pin edges are still watched and held pending in run mode
// - registers stay readable and writable in non-low-leakage modes
// - an enabled pin filter starts operating immediately, before any stop mode
// - a pin edge up to 5 clocks before entry still counts
// - after a stop entered during debug, unit goes inactive on exit
// - edge select 00 off, 01 rising, 10 falling, 11 any change
// - first pin enable register holds pins 3..0 at bits 7-6 down to 1-0
// - second pin enable register holds pins 7..4, pin 7 in bits 7-6
// - writes only in supervisor mode; user writes blocked with bus error
// - registers reset to 00h only on the chip reset excluding deep-stop wakeup
// - flag registers record which pin or module caused the exit
// - detection starts only on entry into a low-leakage mode
// - off after low_leak_stop exit; after very_low_leak_stop until isolation acknowledge
// - in deepest very_low_leak_stop pin filters are disabled and bypassed; here the filter output is bypassed but the filter keeps running
`ifndef LOW_LEAKAGE_WAKEUP_UNIT_DEFINES_SVH
`define LOW_LEAKAGE_WAKEUP_UNIT_DEFINES_SVH
`define LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_LOW    32'h4007C000
`define LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_HIGH   32'h4007C001
`define LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_EN    32'h4007C002
`define LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG  32'h4007C003
`define LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_FLAG  32'h4007C004
`define LOW_LEAKAGE_WAKEUP_UNIT_ADDR_FILT_ONE  32'h4007C005
`define LOW_LEAKAGE_WAKEUP_UNIT_ADDR_FILT_TWO  32'h4007C006
`define LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET      8'h00
`define LOW_LEAKAGE_WAKEUP_UNIT_EDGE_OFF       2'h0
`define LOW_LEAKAGE_WAKEUP_UNIT_EDGE_RISE      2'h1
`define LOW_LEAKAGE_WAKEUP_UNIT_EDGE_FALL      2'h2
`define LOW_LEAKAGE_WAKEUP_UNIT_EDGE_ANY       2'h3
`define LOW_LEAKAGE_WAKEUP_UNIT_FILT_EN_POS    7
`define LOW_LEAKAGE_WAKEUP_UNIT_FILT_SEL_HI    3
`define LOW_LEAKAGE_WAKEUP_UNIT_FILT_SEL_LO    0
`define LOW_LEAKAGE_WAKEUP_UNIT_FILT_LEN       3'h3
`define LOW_LEAKAGE_WAKEUP_UNIT_PRE_ENTRY_CYC  3'h5
`endif

// ==== low_leakage_wakeup_unit_pkg.sv ====
// types for the low-leakage wakeup unit
package low_leakage_wakeup_unit_pkg;
  typedef enum logic [1:0] {
    LOW_LEAKAGE_WAKEUP_UNIT_MODE_RUN,
    LOW_LEAKAGE_WAKEUP_UNIT_MODE_LLS,
    LOW_LEAKAGE_WAKEUP_UNIT_MODE_VERY_LOW_LEAK_STOP,
    LOW_LEAKAGE_WAKEUP_UNIT_MODE_DEEPEST_VERY_LOW_LEAK_STOP
  } low_leakage_wakeup_unit_mode_t;
  typedef enum logic [1:0] {
    LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE,
    LOW_LEAKAGE_WAKEUP_UNIT_ST_DETECT,
    LOW_LEAKAGE_WAKEUP_UNIT_ST_HOLD
  } low_leakage_wakeup_unit_state_t;
endpackage

// ==== low_leakage_wakeup_unit_pin_filter.sv ====
// one digital pin filter: a level must hold for a fixed count to pass
`timescale 1ns/10ps
`include "low_leakage_wakeup_unit_defines.svh"
module low_leakage_wakeup_unit_pin_filter
  import low_leakage_wakeup_unit_pkg::*;
(
  input  wire logic clock_i,  // unit clock
  input  wire logic rstn_i,   // synchronised reset, active low
  input  wire logic enable_i, // filter enabled
  input  wire logic bypass_i, // bypass in deepest stop
  input  wire logic pin_i,    // raw pin level
  output logic      pin_o     // qualified level
);
  logic       stable_ff;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       nxt_stable;
  // count cycles since the raw level last matched the filtered one
  assign nxt_cnt = (pin_i == stable_ff) ? 3'h0 : 3'(cnt_ff + 3'h1);
  assign nxt_stable = (cnt_ff == `LOW_LEAKAGE_WAKEUP_UNIT_FILT_LEN) ? pin_i : stable_ff;
  // runs whenever enabled, independent of power mode
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff    <= 3'h0;
      stable_ff <= 1'b0;
    end else if (enable_i) begin
      cnt_ff    <= (cnt_ff == `LOW_LEAKAGE_WAKEUP_UNIT_FILT_LEN) ? 3'h0 : nxt_cnt;
      stable_ff <= nxt_stable;
    end else begin
      cnt_ff    <= 3'h0;
      stable_ff <= pin_i;
    end
  end
  assign pin_o = (bypass_i || !enable_i) ? pin_i : stable_ff;
endmodule

// ==== low_leakage_wakeup_unit_top.sv ====
// low-leakage wakeup unit: registers, edge detection, flags, wakeup requests
`timescale 1ns/10ps
`include "low_leakage_wakeup_unit_defines.svh"
module low_leakage_wakeup_unit_top
  import low_leakage_wakeup_unit_pkg::*;
(
  input  wire logic        clock_i,       // low-power oscillator clock
  input  wire logic        rstn_i,        // chip reset excluding deep-stop wakeup
  input  wire logic [1:0]  power_mode_i,  // 0 run, 1 lls, 2 very_low_leak_stop, 3 deepest very_low_leak_stop
  input  wire logic        debug_i,       // chip in debug mode
  input  wire logic        iso_ack_i,     // isolation acknowledge write pulse
  input  wire logic [15:0] wakeup_pin_i,  // external wakeup pins
  input  wire logic [7:0]  module_wake_i, // internal module wakeup flags
  input  wire logic        bus_sel_i,     // register access strobe
  input  wire logic        bus_write_i,   // 1 write, 0 read
  input  wire logic        bus_super_i,   // supervisor privilege
  input  wire logic [31:0] bus_addr_i,    // byte address
  input  wire logic [7:0]  bus_wdata_i,   // write data
  output logic [7:0]       bus_rdata_o,   // read data
  output logic             bus_ack_o,     // access done
  output logic             bus_err_o,     // user write refused
  output logic             wake_irq_o,    // interrupt-flow wakeup request
  output logic             wake_rst_o,    // reset-flow wakeup request
  output logic             active_o       // detection logic running
);
  // reset release through two flops
  logic rst_s1_ff;
  logic rst_s2_ff;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire logic rst_n = rst_s2_ff;

  // pin event decode against the selected edge
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur);
    case (sel)
      `LOW_LEAKAGE_WAKEUP_UNIT_EDGE_RISE: edge_hit = !prev && cur;
      `LOW_LEAKAGE_WAKEUP_UNIT_EDGE_FALL: edge_hit = prev && !cur;
      `LOW_LEAKAGE_WAKEUP_UNIT_EDGE_ANY:  edge_hit = prev != cur;
      default:         edge_hit = 1'b0;
    endcase
  endfunction

  logic [7:0] pe_low_ff;
  logic [7:0] pe_high_ff;
  logic [7:0] mod_en_ff;
  logic [7:0] pin_flag_ff;
  logic [7:0] mod_flag_ff;
  logic [7:0] filt_one_ff;
  logic [7:0] filt_two_ff;
  logic [7:0] rdata_ff;
  logic       ack_ff;
  logic       err_ff;
  logic       irq_ff;
  logic       rst_req_ff;
  low_leakage_wakeup_unit_state_t state_ff;
  low_leakage_wakeup_unit_state_t nxt_state;
  low_leakage_wakeup_unit_mode_t  mode_ff;
  logic       in_very_low_leak_stop_ff;
  logic [7:0] pin_prev_ff;
  logic [7:0] pend_ff;
  logic [2:0] pend_age_ff [8];

  // mode view of the power controller input
  wire low_leakage_wakeup_unit_mode_t mode = low_leakage_wakeup_unit_mode_t'(power_mode_i);
  wire logic low_leak = mode != LOW_LEAKAGE_WAKEUP_UNIT_MODE_RUN;
  wire logic deepest  = mode == LOW_LEAKAGE_WAKEUP_UNIT_MODE_DEEPEST_VERY_LOW_LEAK_STOP;

  // register decode; all writes need supervisor privilege
  wire logic hit_pe_low  = bus_addr_i == `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_LOW;
  wire logic hit_pe_high = bus_addr_i == `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_HIGH;
  wire logic hit_mod_en  = bus_addr_i == `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_EN;
  wire logic hit_pflag   = bus_addr_i == `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG;
  wire logic hit_mflag   = bus_addr_i == `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_FLAG;
  wire logic hit_filt1   = bus_addr_i == `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_FILT_ONE;
  wire logic hit_filt2   = bus_addr_i == `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_FILT_TWO;
  wire logic wr_try  = bus_sel_i && bus_write_i;
  wire logic wr_ok   = wr_try && bus_super_i;
  wire logic wr_deny = wr_try && !bus_super_i;

  // filtered pins; only pins 0..7 have edge-select fields here
  wire logic [15:0] pin_edge_sel = {pe_high_ff, pe_low_ff};
  logic [1:0] filt_out;
  wire logic [3:0] filt_pin [2];
  assign filt_pin[0] = filt_one_ff[`LOW_LEAKAGE_WAKEUP_UNIT_FILT_SEL_HI:`LOW_LEAKAGE_WAKEUP_UNIT_FILT_SEL_LO];
  assign filt_pin[1] = filt_two_ff[`LOW_LEAKAGE_WAKEUP_UNIT_FILT_SEL_HI:`LOW_LEAKAGE_WAKEUP_UNIT_FILT_SEL_LO];
  low_leakage_wakeup_unit_pin_filter u_filt0 (
    .clock_i  (clock_i),
    .rstn_i   (rst_n),
    .enable_i (filt_one_ff[`LOW_LEAKAGE_WAKEUP_UNIT_FILT_EN_POS]),
    .bypass_i (deepest),
    .pin_i    (wakeup_pin_i[filt_pin[0]]),
    .pin_o    (filt_out[0])
  );
  low_leakage_wakeup_unit_pin_filter u_filt1 (
    .clock_i  (clock_i),
    .rstn_i   (rst_n),
    .enable_i (filt_two_ff[`LOW_LEAKAGE_WAKEUP_UNIT_FILT_EN_POS]),
    .bypass_i (deepest),
    .pin_i    (wakeup_pin_i[filt_pin[1]]),
    .pin_o    (filt_out[1])
  );

  // pin level after the optional filter
  logic [7:0] pin_lvl;
  always_comb begin
    pin_lvl = wakeup_pin_i[7:0];
    if (filt_one_ff[`LOW_LEAKAGE_WAKEUP_UNIT_FILT_EN_POS] && filt_pin[0] < 4'h8)
      pin_lvl[filt_pin[0][2:0]] = filt_out[0];
    if (filt_two_ff[`LOW_LEAKAGE_WAKEUP_UNIT_FILT_EN_POS] && filt_pin[1] < 4'h8)
      pin_lvl[filt_pin[1][2:0]] = filt_out[1];
  end

  // edge events, watched in every mode so a recent edge survives entry
  logic [7:0] pin_evt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_evt[i] = edge_hit(pin_edge_sel[2*i +: 2], pin_prev_ff[i], pin_lvl[i]);
    end
  end

  // pending edges age out after the pre-entry window
  logic [7:0] pend_live;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pend_live[i] = pend_ff[i] && pend_age_ff[i] < `LOW_LEAKAGE_WAKEUP_UNIT_PRE_ENTRY_CYC;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_ff <= 8'h00;
      pend_ff     <= 8'h00;
      for (int i = 0; i < 8; i++) pend_age_ff[i] <= 3'h0;
    end else begin
      pin_prev_ff <= pin_lvl;
      for (int i = 0; i < 8; i++) begin
        if (pin_evt[i] && state_ff != LOW_LEAKAGE_WAKEUP_UNIT_ST_DETECT) begin
          pend_ff[i]     <= 1'b1;
          pend_age_ff[i] <= 3'h0;
        end else if (pend_live[i]) begin
          pend_age_ff[i] <= 3'(pend_age_ff[i] + 3'h1);
        end else begin
          pend_ff[i] <= 1'b0;
        end
      end
    end
  end

  // sources that fire this cycle while detecting
  wire logic        detecting = state_ff == LOW_LEAKAGE_WAKEUP_UNIT_ST_DETECT;
  // only while the stop is still live, so a late cycle in run never picks a flow
  wire logic        sensing   = detecting && low_leak;
  wire logic [7:0]  pin_fire  = sensing ? (pin_evt | pend_live) : 8'h00;
  wire logic [7:0]  mod_fire  = sensing ? (module_wake_i & mod_en_ff) : 8'h00;
  wire logic        any_fire  = |pin_fire || |mod_fire;

  // activity control: idle in run, detect in stop, hold until released
  always_comb begin
    case (state_ff)
      LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE:   nxt_state = low_leak ? LOW_LEAKAGE_WAKEUP_UNIT_ST_DETECT : LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE;
      LOW_LEAKAGE_WAKEUP_UNIT_ST_DETECT: begin
        if (low_leak)
          nxt_state = LOW_LEAKAGE_WAKEUP_UNIT_ST_DETECT;
        else if (in_very_low_leak_stop_ff && !debug_i && !iso_ack_i)
          nxt_state = LOW_LEAKAGE_WAKEUP_UNIT_ST_HOLD;
        else
          nxt_state = LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE;
      end
      LOW_LEAKAGE_WAKEUP_UNIT_ST_HOLD:   nxt_state = iso_ack_i ? LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE : LOW_LEAKAGE_WAKEUP_UNIT_ST_HOLD;
      default:        nxt_state = LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE;
    endcase
  end
  wire logic hold_detect = state_ff == LOW_LEAKAGE_WAKEUP_UNIT_ST_HOLD;
  // a held very_low_leak_stop unit keeps flagging sources until acknowledge
  wire logic [7:0] hold_pin = hold_detect ? pin_evt : 8'h00;
  wire logic [7:0] hold_mod = hold_detect ? (module_wake_i & mod_en_ff) : 8'h00;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE;
      mode_ff    <= LOW_LEAKAGE_WAKEUP_UNIT_MODE_RUN;
      in_very_low_leak_stop_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      mode_ff    <= mode;
      if (low_leak)
        in_very_low_leak_stop_ff <= mode != LOW_LEAKAGE_WAKEUP_UNIT_MODE_LLS;
    end
  end

  // wakeup requests; flow chosen by the mode we are leaving
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff     <= 1'b0;
      rst_req_ff <= 1'b0;
    end else begin
      // one pulse per exit: the controller leaves stop on the first one
      irq_ff     <= any_fire && mode == LOW_LEAKAGE_WAKEUP_UNIT_MODE_LLS && !irq_ff && !rst_req_ff;
      rst_req_ff <= any_fire && mode != LOW_LEAKAGE_WAKEUP_UNIT_MODE_LLS && !irq_ff && !rst_req_ff;
    end
  end

  // flags: hardware set beats a same-cycle write-one clear
  wire logic [7:0] pin_clr = (wr_ok && hit_pflag) ? bus_wdata_i : 8'h00;
  wire logic [7:0] pin_set = pin_fire | hold_pin;
  wire logic [7:0] mod_set = mod_fire | hold_mod;

  // configuration and flag registers, reset only by the chip reset; pin flags also clear on a write of one
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pe_low_ff   <= `LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET;
      pe_high_ff  <= `LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET;
      mod_en_ff   <= `LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET;
      pin_flag_ff <= `LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET;
      mod_flag_ff <= `LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET;
      filt_one_ff <= `LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET;
      filt_two_ff <= `LOW_LEAKAGE_WAKEUP_UNIT_REG_RESET;
    end else begin
      if (wr_ok && hit_pe_low)  pe_low_ff   <= bus_wdata_i;
      if (wr_ok && hit_pe_high) pe_high_ff  <= bus_wdata_i;
      if (wr_ok && hit_mod_en)  mod_en_ff   <= bus_wdata_i;
      if (wr_ok && hit_filt1)   filt_one_ff <= bus_wdata_i;
      if (wr_ok && hit_filt2)   filt_two_ff <= bus_wdata_i;
      pin_flag_ff <= (pin_flag_ff & ~pin_clr) | pin_set;
      // module flags latch the enabled module sources while detecting or held after very_low_leak_stop
      mod_flag_ff <= detecting || hold_detect ? (mod_flag_ff | mod_set) : mod_flag_ff;
    end
  end

  // bus answer one cycle after the strobe
  wire logic [7:0] rd_mux =
    hit_pe_low  ? pe_low_ff   :
    hit_pe_high ? pe_high_ff  :
    hit_mod_en  ? mod_en_ff   :
    hit_pflag   ? pin_flag_ff :
    hit_mflag   ? mod_flag_ff :
    hit_filt1   ? filt_one_ff :
    hit_filt2   ? filt_two_ff : 8'h00;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      rdata_ff <= (bus_sel_i && !bus_write_i) ? rd_mux : 8'h00;
      ack_ff   <= bus_sel_i && !wr_deny;
      err_ff   <= wr_deny;
    end
  end

  assign bus_rdata_o = rdata_ff;
  assign bus_ack_o   = ack_ff;
  assign bus_err_o   = err_ff;
  assign wake_irq_o  = irq_ff;
  assign wake_rst_o  = rst_req_ff;
  logic active_ff;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) active_ff <= 1'b0;
    else        active_ff <= nxt_state != LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE;
  end
  assign active_o = active_ff;

  // checks
  a_user_write_err: assert property (@(posedge clock_i) disable iff (!rst_n)
    wr_deny |=> bus_err_o && !bus_ack_o) else $error("user write not refused");
  a_user_write_blk: assert property (@(posedge clock_i) disable iff (!rst_n)
    (wr_deny && hit_pe_low) |=> $stable(pe_low_ff)) else $error("user write took effect");
  a_lls_irq_flow: assert property (@(posedge clock_i) disable iff (!rst_n)
    (any_fire && mode == LOW_LEAKAGE_WAKEUP_UNIT_MODE_LLS && !wake_irq_o && !wake_rst_o) |=>
    wake_irq_o && !wake_rst_o)
    else $error("lls wakeup without interrupt");
  a_very_low_leak_stop_rst_flow: assert property (@(posedge clock_i) disable iff (!rst_n)
    (any_fire && mode != LOW_LEAKAGE_WAKEUP_UNIT_MODE_LLS && !wake_irq_o && !wake_rst_o) |=>
    wake_rst_o && !wake_irq_o)
    else $error("very_low_leak_stop wakeup without reset flow");
  a_run_static: assert property (@(posedge clock_i) disable iff (!rst_n)
    (state_ff == LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE) |=> !wake_irq_o && !wake_rst_o)
    else $error("wakeup while idle");
  a_flag_sets: assert property (@(posedge clock_i) disable iff (!rst_n)
    pin_fire[0] |=> pin_flag_ff[0]) else $error("pin flag not set");
  a_off_pin_quiet: assert property (@(posedge clock_i) disable iff (!rst_n)
    (pe_low_ff[1:0] == `LOW_LEAKAGE_WAKEUP_UNIT_EDGE_OFF) |-> !pin_evt[0]) else $error("disabled pin fired");
  a_lls_exit_off: assert property (@(posedge clock_i) disable iff (!rst_n)
    (detecting && !low_leak && !in_very_low_leak_stop_ff) |=> state_ff == LOW_LEAKAGE_WAKEUP_UNIT_ST_IDLE)
    else $error("unit still on after lls exit");
  a_hold_until_ack: assert property (@(posedge clock_i) disable iff (!rst_n)
    (hold_detect && !iso_ack_i) |=> hold_detect) else $error("hold left without ack");
  c_lls_wake:  cover property (@(posedge clock_i) disable iff (!rst_n) wake_irq_o);
  c_very_low_leak_stop_wake: cover property (@(posedge clock_i) disable iff (!rst_n) wake_rst_o);
  c_user_err:  cover property (@(posedge clock_i) disable iff (!rst_n) bus_err_o);
endmodule

// ==== low_leakage_wakeup_unit_pmc_model.sv ====
// power mode controller model: enters stop on request, leaves on wakeup
`timescale 1ns/10ps
module low_leakage_wakeup_unit_pmc_model (
  input  wire logic       clock_i,      // unit clock
  input  wire logic       rstn_i,       // reset, active low
  input  wire logic       req_i,        // mode change request
  input  wire logic [1:0] req_mode_i,   // requested mode
  input  wire logic       wake_irq_i,   // interrupt-flow wakeup
  input  wire logic       wake_rst_i,   // reset-flow wakeup
  output logic [1:0]      power_mode_o, // current mode
  output logic [7:0]      irq_cnt_o,    // interrupt flows taken
  output logic [7:0]      rst_cnt_o     // reset flows taken
);
  logic [1:0] mode_ff;
  logic [7:0] irq_ff;
  logic [7:0] rst_ff;
  // wakeup interrupt never masked, so every request completes the exit
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_ff <= 2'h0;
      irq_ff  <= 8'h00;
      rst_ff  <= 8'h00;
    end else if (wake_irq_i || wake_rst_i) begin
      mode_ff <= 2'h0;
      irq_ff  <= irq_ff + {7'h00, wake_irq_i};
      rst_ff  <= rst_ff + {7'h00, wake_rst_i};
    end else if (req_i) begin
      mode_ff <= req_mode_i;
    end
  end
  assign power_mode_o = mode_ff;
  assign irq_cnt_o    = irq_ff;
  assign rst_cnt_o    = rst_ff;
endmodule

// ==== tb.sv ====
// self-checking bench for the low-leakage wakeup unit
`timescale 1ns/10ps
`include "low_leakage_wakeup_unit_defines.svh"
module tb;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        debug_i = 1'b0;
  logic        iso_ack_i = 1'b0;
  logic [15:0] pin = 16'h0000;
  logic [7:0]  mwake = 8'h00;
  logic        sel = 1'b0;
  logic        wr_en = 1'b0;
  logic        sup = 1'b0;
  logic [31:0] addr = 32'h00000000;
  logic [7:0]  wdata = 8'h00;
  logic        req = 1'b0;
  logic [1:0]  req_mode = 2'h0;
  logic [1:0]  mode;
  logic [7:0]  rdata, irq_cnt, rst_cnt, r, bi, br;
  logic        ack, err, irq, rst, active, k, x;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #5 clock_i = ~clock_i;

  low_leakage_wakeup_unit_top low_leakage_wakeup_unit_top_inst (.clock_i(clock_i), .rstn_i(rstn_i), .power_mode_i(mode),
    .debug_i(debug_i), .iso_ack_i(iso_ack_i), .wakeup_pin_i(pin), .module_wake_i(mwake),
    .bus_sel_i(sel), .bus_write_i(wr_en), .bus_super_i(sup), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_ack_o(ack), .bus_err_o(err),
    .wake_irq_o(irq), .wake_rst_o(rst), .active_o(active));

  low_leakage_wakeup_unit_pmc_model low_leakage_wakeup_unit_pmc_model_inst (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req),
    .req_mode_i(req_mode), .wake_irq_i(irq), .wake_rst_i(rst), .power_mode_o(mode),
    .irq_cnt_o(irq_cnt), .rst_cnt_o(rst_cnt));

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one access: strobe for one cycle, answer within a bounded wait
  task automatic bus(input logic w, input logic s, input logic [31:0] a, input logic [7:0] d);
    int n;
    @(posedge clock_i);
    #1;
    sel = 1'b1;
    wr_en = w;
    sup = s;
    addr = a;
    wdata = d;
    @(posedge clock_i);
    #1;
    sel = 1'b0;
    for (n = 0; n < 4 && ack !== 1'b1 && err !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    if (n == 4) begin
      miscompares++;
      tally_and_finish();
    end
    k = ack;
    x = err;
    r = rdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, 1'b1, a, d);
    chk(k, 1'b1);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    chk(k, 1'b1);
    chk(r, e);
  endtask

  // mode request; wakeup counts are taken as baseline here
  task automatic enter(input logic [1:0] m);
    bi = irq_cnt;
    br = rst_cnt;
    @(posedge clock_i);
    #1;
    req = 1'b1;
    req_mode = m;
    @(posedge clock_i);
    #1;
    req = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  task automatic wake(input logic [7:0] ei, input logic [7:0] er);
    repeat (12) @(posedge clock_i);
    #1;
    chk(irq_cnt - bi, ei);
    chk(rst_cnt - br, er);
  endtask

  // a hang is cut short here
  initial begin
    #500000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    int p;
    logic [1:0] pb;
    repeat (20) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    repeat (5) @(posedge clock_i);
    for (p = 0; p < 7; p++) rdc(32'h4007C000 + p, 8'h00);
    rdc(32'h4007C007, 8'h00);
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_LOW, 8'hE4);
    rdc(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_LOW, 8'hE4);
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_HIGH, 8'h40);
    bus(1'b1, 1'b0, `LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_HIGH, 8'h12);
    chk({x, k}, 2'h2);
    rdc(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_HIGH, 8'h40);
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_FLAG, 8'hFF);
    rdc(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_FLAG, 8'h00);
    // module 1 active but not enabled: only module 0 may show
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_EN, 8'h01);
    mwake = 8'h03;
    enter(2'h0);
    wake(8'h00, 8'h00);
    chk(active, 1'b0);
    enter(2'h1);
    wake(8'h01, 8'h00);
    chk(active, 1'b0);
    rdc(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_MOD_FLAG, 8'h01);
    mwake = 8'h00;
    // pin p carries edge code p: rise then fall on each
    for (p = 0; p < 4; p++) begin
      pb = p[1:0];
      enter(2'h1);
      pin[p] = 1'b1;
      wake({7'h00, pb[0]}, 8'h00);
      enter(2'h0);
      rdc(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG, pb[0] ? 8'h01 << p : 8'h00);
      wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG, 8'hFF);
      enter(2'h1);
      pin[p] = 1'b0;
      wake({7'h00, pb[1]}, 8'h00);
      enter(2'h0);
      rdc(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG, pb[1] ? 8'h01 << p : 8'h00);
      wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG, 8'hFF);
    end
    // edge two cycles ahead of entry must still wake
    pin[1] = 1'b1;
    enter(2'h1);
    wake(8'h01, 8'h00);
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG, 8'hFF);
    enter(2'h2);
    pin[7] = 1'b1;
    wake(8'h00, 8'h01);
    chk(active, 1'b1);
    rdc(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG, 8'h80);
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PIN_FLAG, 8'hFF);
    @(posedge clock_i);
    #1;
    iso_ack_i = 1'b1;
    @(posedge clock_i);
    #1;
    iso_ack_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk(active, 1'b0);
    // deepest stop from debug: filter on pin 7 is bypassed
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_FILT_ONE, 8'h87);
    wr(`LOW_LEAKAGE_WAKEUP_UNIT_ADDR_PE_HIGH, 8'h80);
    debug_i = 1'b1;
    enter(2'h3);
    pin[7] = 1'b0;
    wake(8'h00, 8'h01);
    chk(active, 1'b0);
    debug_i = 1'b0;
    tally_and_finish();
  end
endmodule
